//--- core/ufc_top.sv
// FIFO control register, thresholds, flush sequencing and interrupt
//
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "ufc_cfg.svh"
// Register map, by byte offset on the bus port:
//   0x0 config: bit 0 enables automatic RTS flow control
//   0x4 status: bit 0 receive data available, bit 1 hold level reached; a read clears it
//   0x8 FIFO control: thresholds, receiver off and the two flush strobes
//   0xc mask: same layout as status; the interrupt is high while status and mask overlap
// The receive byte count arrives from the FIFO every cycle. A flag fires when the count
// arrives at its level, so a count that rests there raises it only once.
// A flush strobe reads back as 1 while its reset pulse runs and clears itself after it;
// the pulse lasts a fixed number of cycles, which bounds how soon the FIFO may be used.
// HIGH_SPEED opens the 30, 46 and 62 byte levels. HAS_AUTO_RTS is off on the channel
// without flow control, where the flow-hold field reads zero and ignores writes.
// Every access costs one wait cycle; back-to-back requests are taken after each answer.
module ufc_top #(
	parameter bit HIGH_SPEED = 1'b1,
	parameter bit HAS_AUTO_RTS = 1'b1
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [6:0] rx_fifo_count,
	output logic rts_n,
	output logic receiver_enable,
	output logic tx_fifo_reset,
	output logic rx_fifo_reset,
	output logic rx_data_avail_irq
);
	ufc_pkg::ufc_state_s s_reg, s_next;

	// Trigger level in bytes; codes above 3 reach past 14 only on the high-speed channel
	function automatic logic [6:0] level(input logic [3:0] code);
		logic [6:0] v;
		v = `UFC_LEVEL_14;
		case (code)
			4'h0: begin
				v = `UFC_LEVEL_1;
			end
			4'h1: begin
				v = `UFC_LEVEL_4;
			end
			4'h2: begin
				v = `UFC_LEVEL_8;
			end
			4'h3: begin
				v = `UFC_LEVEL_14;
			end
			4'h4: begin
				if (HIGH_SPEED) begin
					v = `UFC_LEVEL_30;
				end else begin
					v = `UFC_LEVEL_14;
				end
			end
			4'h5: begin
				if (HIGH_SPEED) begin
					v = `UFC_LEVEL_46;
				end else begin
					v = `UFC_LEVEL_14;
				end
			end
			default: begin
				if (HIGH_SPEED) begin
					v = `UFC_LEVEL_62;
				end else begin
					v = `UFC_LEVEL_14;
				end
			end
		endcase
		return v;
	endfunction

	// Decoded request, threshold and read signals
	logic wr;
	logic rd;
	logic hit_rts;
	logic hit_rda;
	logic below_rts;
	logic [31:0] wmask;
	logic [31:0] rd_word;
	logic sel_fifo_control;
	logic sel_config;
	logic sel_status;
	logic sel_mask;
	logic [3:0] rts_code;
	logic [3:0] rda_code;
	logic [6:0] rts_level;
	logic [6:0] rda_level;
	logic count_moved;
	logic flow_active;
	logic rda_event;
	logic hold_event;

	// Reset image: register at zero, RTS asserted and receiver on,
	// so the far side may send as soon as reset ends
	localparam ufc_pkg::ufc_state_s reset_state = '{
		fcr: `UFC_FCR_RESET,
		auto_rts: 1'b0,
		status: 2'h0,
		mask: 2'h0,
		tx_st: ufc_pkg::ufc_idle,
		rx_st: ufc_pkg::ufc_idle,
		tx_cnt: 2'h0,
		rx_cnt: 2'h0,
		rdata: 32'h0000_0000,
		rvalid: 1'b0,
		wait_n: 1'b0,
		rts: 1'b1,
		irq: 1'b0,
		tx_rst: 1'b0,
		rx_rst: 1'b0,
		rx_en: 1'b1,
		prev_cnt: 7'h00
	};

	// Address decode, writable fields and threshold lookup, shared by write, read and flags
	always_comb begin
		sel_fifo_control = avs_address == `UFC_OFS_FIFO_CONTROL;
		sel_config = avs_address == `UFC_OFS_CONFIG;
		sel_status = avs_address == `UFC_OFS_STATUS;
		sel_mask = avs_address == `UFC_OFS_MASK;
		// The channel without flow control has no flow-hold field at all
		wmask = 32'h0000_0000;
		wmask[`UFC_FLD_RDA_HI:`UFC_FLD_RDA_LO] = 4'hf;
		wmask[`UFC_BIT_RX_OFF] = 1'b1;
		wmask[`UFC_BIT_TX_FLUSH] = 1'b1;
		wmask[`UFC_BIT_RX_FLUSH] = 1'b1;
		if (HAS_AUTO_RTS) begin
			wmask[`UFC_FLD_RTS_HI:`UFC_FLD_RTS_LO] = 4'hf;
		end

		rts_code = s_reg.fcr[`UFC_FLD_RTS_HI:`UFC_FLD_RTS_LO];
		rda_code = s_reg.fcr[`UFC_FLD_RDA_HI:`UFC_FLD_RDA_LO];
		rts_level = level(rts_code);
		rda_level = level(rda_code);
		hit_rts = rx_fifo_count == rts_level;
		hit_rda = rx_fifo_count == rda_level;
		below_rts = rx_fifo_count < rts_level;
		// Flags fire on the cycle the count arrives at a level, not while it rests there
		count_moved = s_reg.prev_cnt != rx_fifo_count;
		flow_active = s_reg.auto_rts && HAS_AUTO_RTS;
		rda_event = hit_rda && count_moved;
		hold_event = hit_rts && flow_active && count_moved;

		// Read word for the addressed register; unmapped offsets read zero
		rd_word = 32'h0000_0000;
		if (sel_fifo_control) begin
			rd_word = s_reg.fcr;
		end
		if (sel_config) begin
			rd_word = {31'h0000_0000, s_reg.auto_rts};
		end
		if (sel_status) begin
			rd_word = {30'h0000_0000, s_reg.status};
		end
		if (sel_mask) begin
			rd_word = {30'h0000_0000, s_reg.mask};
		end
	end

	always_comb begin
		s_next = s_reg;
		// One wait cycle per access. Reads are looked up in the first cycle so the data
		// already stands when waitrequest drops; writes land at the edge that sees it low,
		// the only edge at which the master is bound to hold its data.
		wr = 1'b0;
		rd = 1'b0;
		if (s_reg.wait_n) begin
			wr = avs_write;
		end else begin
			rd = avs_read;
		end
		s_next.wait_n = !s_reg.wait_n && (avs_read || avs_write);
		s_next.rvalid = 1'b0;

		// Register writes; reserved positions are masked off
		if (wr) begin
			if (sel_fifo_control) begin
				s_next.fcr = avs_writedata & wmask & ~`UFC_FLUSH_BITS;
				// A 0 in a flush bit leaves a running flush alone
				s_next.fcr[`UFC_BIT_TX_FLUSH] = s_reg.fcr[`UFC_BIT_TX_FLUSH] | avs_writedata[`UFC_BIT_TX_FLUSH];
				s_next.fcr[`UFC_BIT_RX_FLUSH] = s_reg.fcr[`UFC_BIT_RX_FLUSH] | avs_writedata[`UFC_BIT_RX_FLUSH];
			end
			if (sel_config) begin
				s_next.auto_rts = avs_writedata[`UFC_BIT_AUTO_RTS] && HAS_AUTO_RTS;
			end
			if (sel_mask) begin
				s_next.mask = avs_writedata[1:0];
			end
		end

		// Flush sequencers: a 1 starts a fixed-length reset pulse to the FIFO side.
		// A further 1 while busy merges into the running flush rather than stretching it.
		case (s_reg.tx_st)
			ufc_pkg::ufc_idle: begin
				if (s_next.fcr[`UFC_BIT_TX_FLUSH]) begin
					s_next.tx_st = ufc_pkg::ufc_busy;
					s_next.tx_cnt = `UFC_FLUSH_CYCLES;
				end
			end
			ufc_pkg::ufc_busy: begin
				s_next.tx_cnt = s_reg.tx_cnt - 2'h1;
				if (s_reg.tx_cnt == 2'h1) begin
					s_next.tx_st = ufc_pkg::ufc_idle;
					s_next.fcr[`UFC_BIT_TX_FLUSH] = 1'b0;
				end
			end
			default: begin
				s_next.tx_st = ufc_pkg::ufc_idle;
			end
		endcase

		case (s_reg.rx_st)
			ufc_pkg::ufc_idle: begin
				if (s_next.fcr[`UFC_BIT_RX_FLUSH]) begin
					s_next.rx_st = ufc_pkg::ufc_busy;
					s_next.rx_cnt = `UFC_FLUSH_CYCLES;
				end
			end
			ufc_pkg::ufc_busy: begin
				s_next.rx_cnt = s_reg.rx_cnt - 2'h1;
				if (s_reg.rx_cnt == 2'h1) begin
					s_next.rx_st = ufc_pkg::ufc_idle;
					s_next.fcr[`UFC_BIT_RX_FLUSH] = 1'b0;
				end
			end
			default: begin
				s_next.rx_st = ufc_pkg::ufc_idle;
			end
		endcase

		// FIFO-side outputs follow the next state so they line up with the register
		s_next.tx_rst = (s_next.tx_st == ufc_pkg::ufc_busy);
		s_next.rx_rst = (s_next.rx_st == ufc_pkg::ufc_busy);
		s_next.rx_en = !s_next.fcr[`UFC_BIT_RX_OFF];
		s_next.prev_cnt = rx_fifo_count;

		// Drop RTS at the hold level; raise it again once the count falls below.
		// Between the two, for instance while the count overshoots, RTS keeps its value.
		if (!flow_active) begin
			s_next.rts = 1'b1;
		end else if (hit_rts) begin
			s_next.rts = 1'b0;
		end else if (below_rts) begin
			s_next.rts = 1'b1;
		end

		if (rd) begin
			s_next.rvalid = 1'b1;
			s_next.rdata = rd_word;
			if (sel_status) begin
				// Read clears; an event in this same cycle sets the bit again below
				s_next.status = 2'h0;
			end
		end

		// Set wins over read-clear; bit 1 records that the hold level was reached
		if (rda_event) begin
			s_next.status[`UFC_ST_RDA] = 1'b1;
		end
		if (hold_event) begin
			s_next.status[`UFC_ST_HOLD] = 1'b1;
		end

		// Level interrupt: any status bit that its mask bit lets through
		s_next.irq = 1'b0;
		for (int b = 0; b < 2; b++) begin
			if (s_next.status[b] && s_next.mask[b]) begin
				s_next.irq = 1'b1;
			end
		end
	end

	// The asynchronous branch loads only the constant reset image
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			s_reg <= reset_state;
		end else begin
			s_reg <= s_next;
		end
	end

	// Outputs are plain views of state flip-flops
	// Read data stands from the edge after the request until the next read
	assign avs_readdata = s_reg.rdata;
	// Low for the single answer cycle of each access
	assign avs_waitrequest = !s_reg.wait_n;
	// Low while the far side may send; high once the hold level is reached
	assign rts_n = !s_reg.rts;
	// Follows the receiver-off bit from the same edge at which the write lands
	assign receiver_enable = s_reg.rx_en;
	// Fixed-length pulses; a request during a running pulse merges into it
	assign tx_fifo_reset = s_reg.tx_rst;
	assign rx_fifo_reset = s_reg.rx_rst;
	// Level output, cleared by reading status or by masking
	assign rx_data_avail_irq = s_reg.irq;
endmodule

//--- core/ufc_cfg.svh
// Constants for the UART FIFO control block
// Functional notes
// - Flow-hold codes 0..3 give RTS levels 1, 4, 8, 14 bytes.
// - Flow-hold codes 4, 5, 6+ give 30, 46, 62 high-speed; 14 otherwise.
// - With auto RTS enabled, drop RTS when receive count equals flow-hold level.
// - Receiver-off bit 8 set disables the receiver; clear keeps it enabled.
// - Receive count equal to rx-fill level sets the data-available flag; irq if enabled.
// - Rx-fill codes 0..3 give 1, 4, 8, 14 bytes.
// - Rx-fill codes 4, 5, 6+ give 30, 46, 62 high-speed; 14 otherwise.
// - Writing 1 to bit 2 flushes transmit FIFO, state machine and pointers.
// - Writing 1 to bit 1 flushes receive FIFO, state machine and pointers.
// - Flush bits self-clear after the reset, taking at least 3 cycles.
// - Writing 0 to a flush bit has no effect.
// - Third channel has no flow-hold threshold and no auto RTS.
// - FIFO control register resets to all zeros.
`ifndef UFC_CFG_SVH
`define UFC_CFG_SVH
`define UFC_OFS_FIFO_CONTROL 4'h8
`define UFC_OFS_CONFIG 4'h0
`define UFC_OFS_STATUS 4'h4
`define UFC_OFS_MASK 4'hc
`define UFC_FCR_RESET 32'h0000_0000
`define UFC_FCR_WMASK 32'h000f_01f6
`define UFC_BIT_RX_FLUSH 1
`define UFC_BIT_TX_FLUSH 2
`define UFC_BIT_RX_OFF 8
`define UFC_FLUSH_CYCLES 2'h3
`define UFC_FLUSH_BITS 32'h0000_0006
`define UFC_BIT_AUTO_RTS 0
`define UFC_ST_RDA 0
`define UFC_ST_HOLD 1
`define UFC_FLD_RTS_HI 19
`define UFC_FLD_RTS_LO 16
`define UFC_FLD_RDA_HI 7
`define UFC_FLD_RDA_LO 4
`define UFC_LEVEL_1 7'h01
`define UFC_LEVEL_4 7'h04
`define UFC_LEVEL_8 7'h08
`define UFC_LEVEL_14 7'h0e
`define UFC_LEVEL_30 7'h1e
`define UFC_LEVEL_46 7'h2e
`define UFC_LEVEL_62 7'h3e
`endif

//--- core/ufc_pkg.sv
// Types for the UART FIFO control block
package ufc_pkg;
	typedef enum logic [1:0] {ufc_idle, ufc_busy} ufc_flush_e;
	typedef struct packed {
		logic [31:0] fcr;
		logic auto_rts;
		logic [1:0] status;
		logic [1:0] mask;
		ufc_flush_e tx_st;
		ufc_flush_e rx_st;
		logic [1:0] tx_cnt;
		logic [1:0] rx_cnt;
		logic [31:0] rdata;
		logic rvalid;
		logic wait_n;
		logic rts;
		logic irq;
		logic tx_rst;
		logic rx_rst;
		logic rx_en;
		logic [6:0] prev_cnt;
	} ufc_state_s;
endpackage

//--- tb/ufc_assertions.sv
// Checks at the ports of the FIFO control block
`timescale 1ns/1ps
module ufc_assertions (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic receiver_enable,
	input wire logic tx_fifo_reset,
	input wire logic rx_fifo_reset
);
	wire logic fw = avs_write && !avs_waitrequest && avs_address == 4'h8;
	wire logic ft = fw && avs_writedata[2];
	wire logic fr = fw && avs_writedata[1];
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	property p_tl; $rose(tx_fifo_reset) |-> tx_fifo_reset[*3] ##1 !tx_fifo_reset; endproperty
	a_tl: assert property (p_tl) else $error("tx len");
	property p_rl; $rose(rx_fifo_reset) |-> rx_fifo_reset[*3] ##1 !rx_fifo_reset; endproperty
	a_rl: assert property (p_rl) else $error("rx len");
	property p_tc; $rose(tx_fifo_reset) |-> $past(ft) || $past(ft, 2); endproperty
	a_tc: assert property (p_tc) else $error("tx cause");
	property p_rc; $rose(rx_fifo_reset) |-> $past(fr) || $past(fr, 2); endproperty
	a_rc: assert property (p_rc) else $error("rx cause");
	property p_tf; ft |-> ##[1:2] tx_fifo_reset; endproperty
	a_tf: assert property (p_tf) else $error("tx flush");
	property p_ro; fw && avs_writedata[8] |-> ##[1:2] !receiver_enable; endproperty
	a_ro: assert property (p_ro) else $error("rx off");
	property p_re; fw && !avs_writedata[8] |-> ##[1:2] receiver_enable; endproperty
	a_re: assert property (p_re) else $error("rx on");
	property p_rv; avs_read && !avs_waitrequest && avs_address == 4'h8 |-> !(avs_readdata & 32'hfff0_fe09); endproperty
	a_rv: assert property (p_rv) else $error("reserved");
endmodule
bind ufc_top ufc_assertions i_ufc_assertions (.mclk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
	.avs_readdata, .avs_waitrequest, .receiver_enable, .tx_fifo_reset, .rx_fifo_reset);

//--- tb/ufc_rx_model.sv
// Receive FIFO fill count fed by the serial side
`timescale 1ns/1ps
module ufc_rx_model (
	input wire logic mclk,
	input wire logic rst,
	input wire logic flush,
	input wire logic push,
	output logic [6:0] count
);
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			count <= 7'h00;
		else if (flush)
			count <= 7'h00;
		else if (push)
			count <= count + 7'h01;
	end
endmodule

//--- tb/uart_fifo_control_tb_top.sv
// Register-level bench of the FIFO control block
`timescale 1ns/1ps
module uart_fifo_control_tb_top;
	logic mclk, rst, avs_read, avs_write, avs_waitrequest, push, done, rts_n, receiver_enable, rx_fifo_reset, irq;
	logic [3:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic [6:0] rx_fifo_count;
	int err_count, total_checks, lv[8] = '{1, 4, 8, 14, 30, 46, 62, 62};
	ufc_top i_ufc_top (.mclk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
		.avs_waitrequest, .rx_fifo_count, .rts_n, .receiver_enable, .tx_fifo_reset(), .rx_fifo_reset,
		.rx_data_avail_irq(irq));
	ufc_rx_model i_ufc_rx_model (.mclk, .rst, .flush(rx_fifo_reset), .push, .count(rx_fifo_count));
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	// Release happens at the very edge that sees waitrequest low
	always @(posedge mclk) if ((avs_read || avs_write) && avs_waitrequest === 1'b0) begin
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		q <= avs_readdata;
		done <= 1'b1;
	end
	task automatic chk(string s, logic [31:0] g, e);
		total_checks++;
		if (g !== e) begin
			err_count++;
			$display("ERROR %s exp %h got %h", s, e, g);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic acc(logic w, logic [3:0] a, logic [31:0] d);
		avs_write <= w;
		avs_read <= !w;
		avs_address <= a;
		avs_writedata <= d;
		for (int n = 0; n < 99 && done !== 1'b1; n++) @(posedge mclk);
		if (done !== 1'b1) begin
			err_count++;
			complete_run();
		end
		done <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic psh(int n);
		repeat (n) begin
			push <= 1'b1;
			@(posedge mclk);
		end
		push <= 1'b0;
		repeat (3) @(posedge mclk);
	endtask
	initial begin
		{rst, avs_read, avs_write, push, done, avs_address, avs_writedata} = {5'h10, 36'h0};
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		acc(1'b0, 4'h8, 32'h0);
		chk("fcr", q, 32'h0);
		acc(1'b1, 4'h8, 32'hffff_fff9);
		acc(1'b0, 4'h8, 32'h0);
		chk("fcr", q, 32'h000f_01f0);
		chk("rx enable", receiver_enable, 32'h0);
		acc(1'b1, 4'h8, 32'h4);
		repeat (5) @(posedge mclk);
		acc(1'b0, 4'h8, 32'h0);
		chk("fcr", q, 32'h0);
		chk("rx enable", receiver_enable, 32'h1);
		acc(1'b0, 4'h2, 32'h0);
		chk("unmapped", q, 32'h0);
		$display("test regs done");
		acc(1'b1, 4'h0, 32'h1);
		acc(1'b1, 4'hc, 32'h1);
		for (int k = 0; k < 8; k++) begin
			acc(1'b1, 4'h8, 32'(k) << 16 | 32'(k) << 4 | 32'h2);
			repeat (5) @(posedge mclk);
			acc(1'b0, 4'h4, 32'h0);
			psh(lv[k] - 1);
			chk("irq", irq, 32'h0);
			chk("rts", rts_n, 32'h0);
			psh(1);
			chk("irq", irq, 32'h1);
			chk("rts", rts_n, 32'h1);
		end
		acc(1'b1, 4'hc, 32'h0);
		chk("irq masked", irq, 32'h0);
		$display("test levels done");
		complete_run();
	end
endmodule
